// [design/ifsi_pkg.sv]
// Shared constants and types for the two-wire memory slave interface
package ifsi_pkg;

    // ------------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int HI_ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;

    // ------------------------------------------------------------------
    // Bit counter marks within one byte frame
    // ------------------------------------------------------------------
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_ACK_DONE = 4'h9;

    // ------------------------------------------------------------------
    // Device address byte fields
    // ------------------------------------------------------------------
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 1;
    localparam int RW_POS = 0;
    localparam int MSB_POS = 7;
    localparam int NEXT_POS = 6;

    // ------------------------------------------------------------------
    // Layout of the synchronised pin vector
    // ------------------------------------------------------------------
    localparam int SYNC_W = 6;
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_CS_LO = 2;
    localparam int SY_CS_HI = 4;
    localparam int SY_WP = 5;

    // Transaction phase
    typedef enum logic [2:0] {
        IFSI_IDLE,
        IFSI_DEV,
        IFSI_ADDR_HI,
        IFSI_ADDR_LO,
        IFSI_WDATA,
        IFSI_RDATA
    } ifsi_state_t;

endpackage : ifsi_pkg

// [design/ifsi_mem_if.sv]
// Port bundle between the protocol engine and the storage array
`timescale 1ns/1ps
interface ifsi_mem_if;
    import ifsi_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic we;

    modport ctrl (output addr, output wdata, output we, input rdata);
    modport array (input addr, input wdata, input we, output rdata);
endinterface : ifsi_mem_if

// [design/ifsi_sync.sv]
// Two-flop synchronisers for the asynchronous pins
`timescale 1ns/1ps
module ifsi_sync
    import ifsi_pkg::*;
#(
    parameter int W = SYNC_W
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // One synchroniser pair per pin; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q[gi] <= 1'b1;
                    sync_out[gi] <= 1'b1;
                end
                else
                begin
                    meta_q[gi] <= async_in[gi];
                    sync_out[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule : ifsi_sync

// [design/ifsi_mem_array.sv]
// Byte-wide storage array with one write and one registered read port
`timescale 1ns/1ps
module ifsi_mem_array
    import ifsi_pkg::*;
(
    input wire logic mclk,
    ifsi_mem_if.array mem
);

    logic [DATA_W-1:0] store [MEM_DEPTH];
    logic [DATA_W-1:0] rdata_q;

    // Write on strobe, read the addressed byte every cycle
    always_ff @(posedge mclk)
    begin
        if (mem.we)
        begin
            store[mem.addr] <= mem.wdata;
        end
        rdata_q <= store[mem.addr];
    end

    assign mem.rdata = rdata_q;

endmodule : ifsi_mem_array

// [design/ifsi_slave.sv]
// Two-wire serial slave engine in front of the byte memory array
`timescale 1ns/1ps
module ifsi_slave
    import ifsi_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = 4'h6 // Arbitrary type code
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect
);

    // ------------------------------------------------------------------
    // Pin synchronisation and bus condition detection
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] cs_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    ifsi_sync #(.W(SYNC_W)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({write_protect, chip_select_pins, sda_in, scl_in}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[SY_SCL];
    assign sda_s = pins_s[SY_SDA];
    assign wp_s = pins_s[SY_WP];
    assign cs_s = pins_s[SY_CS_HI:SY_CS_LO];

    // Previous levels of the synchronised clock and data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Clock edges, and data edges while the clock stays high
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    ifsi_state_t state_q;
    logic [3:0] cnt_q;
    logic [DATA_W-1:0] rx_q;
    logic [DATA_W-1:0] rx_byte;
    logic [DATA_W-1:0] tx_q;
    logic [ADDR_W-1:0] addr_q;
    logic [HI_ADDR_W-1:0] addr_hi_q;
    logic ack_q;
    logic rw_q;
    logic sda_oe_q;
    logic sda_out_q;
    logic busy;
    logic byte_done;
    logic dev_match;
    logic wr_commit;
    logic addr_step;

    ifsi_mem_if mem ();

    ifsi_mem_array u_array (
        .mclk(mclk),
        .mem(mem.array)
    );

    // Incoming byte as it stands after the eighth rising edge
    assign rx_byte = {rx_q[NEXT_POS:0], sda_s};
    assign busy = (state_q != IFSI_IDLE);
    assign byte_done = busy && scl_rise && (cnt_q == CNT_LAST);
    assign dev_match = (rx_byte[TYPE_HI:TYPE_LO] == DEVICE_TYPE)
        && (rx_byte[SEL_HI:SEL_LO] == cs_s);

    // Write commit and latch step; protection blocks the commit and the write step, not the read step
    assign wr_commit = byte_done && (state_q == IFSI_WDATA) && !wp_s;
    assign addr_step = wr_commit || (byte_done && (state_q == IFSI_RDATA));

    // Memory port follows the address latch directly
    assign mem.addr = addr_q;
    assign mem.wdata = rx_byte;
    assign mem.we = wr_commit;

    // ------------------------------------------------------------------
    // Sequencer: phase and bit count
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= IFSI_IDLE;
            cnt_q <= CNT_ZERO;
        end
        else if (start_det)
        begin
            state_q <= IFSI_DEV;
            cnt_q <= CNT_ZERO;
        end
        else if (stop_det)
        begin
            state_q <= IFSI_IDLE;
            cnt_q <= CNT_ZERO;
        end
        else if (busy && scl_rise)
        begin
            if (cnt_q < CNT_LAST)
            begin
                cnt_q <= cnt_q + CNT_FIRST;
            end
            else if (cnt_q == CNT_LAST)
            begin
                cnt_q <= CNT_ACK;
                if (state_q == IFSI_DEV && !dev_match)
                begin
                    state_q <= IFSI_IDLE;
                end
            end
            else if (cnt_q == CNT_ACK)
            begin
                cnt_q <= CNT_ACK_DONE;
                if (state_q == IFSI_RDATA && sda_s)
                begin
                    state_q <= IFSI_IDLE;
                end
            end
        end
        else if (busy && scl_fall && cnt_q == CNT_ACK_DONE)
        begin
            // End of the acknowledge clock selects the next byte kind
            cnt_q <= CNT_ZERO;
            if (!ack_q && state_q != IFSI_RDATA)
            begin
                state_q <= IFSI_IDLE;
            end
            else
            begin
                unique case (state_q)
                    IFSI_DEV:
                        state_q <= rw_q ? IFSI_RDATA : IFSI_ADDR_HI;
                    IFSI_ADDR_HI:
                        state_q <= IFSI_ADDR_LO;
                    IFSI_ADDR_LO:
                        state_q <= IFSI_WDATA;
                    IFSI_WDATA:
                        state_q <= IFSI_WDATA;
                    IFSI_RDATA:
                        state_q <= IFSI_RDATA;
                    IFSI_IDLE:
                        state_q <= IFSI_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive shifter, sampled on rising clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_q <= '0;
        end
        else if (busy && scl_rise && cnt_q <= CNT_LAST)
        begin
            rx_q <= rx_byte;
        end
    end

    // Acknowledge decision and direction, taken at the eighth bit
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rw_q <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            ack_q <= 1'b0;
        end
        else if (byte_done)
        begin
            unique case (state_q)
                IFSI_DEV:
                begin
                    ack_q <= dev_match;
                    rw_q <= rx_byte[RW_POS];
                end
                IFSI_ADDR_HI, IFSI_ADDR_LO:
                    ack_q <= 1'b1;
                IFSI_WDATA:
                    ack_q <= !wp_s;
                IFSI_RDATA, IFSI_IDLE:
                    ack_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Address latch: load from two bytes, step after each read byte and each unprotected write byte
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_hi_q <= '0;
            addr_q <= ADDR_RESET;
        end
        else if (byte_done && state_q == IFSI_ADDR_HI)
        begin
            addr_hi_q <= rx_byte[HI_ADDR_W-1:0];
        end
        else if (byte_done && state_q == IFSI_ADDR_LO)
        begin
            addr_q <= {addr_hi_q, rx_byte};
        end
        else if (addr_step)
        begin
            addr_q <= addr_q + ADDR_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Data line driver, driven on falling clock edges only, released at start, stop or idle
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            tx_q <= '0;
        end
        else if (start_det || stop_det || !busy)
        begin
            sda_oe_q <= 1'b0;
        end
        else if (scl_fall)
        begin
            if (cnt_q == CNT_ACK_DONE && (state_q == IFSI_RDATA
                || (state_q == IFSI_DEV && rw_q && ack_q)))
            begin
                // Phase is still DEV on the fall ending a read address
                tx_q <= mem.rdata;
                sda_oe_q <= !mem.rdata[MSB_POS];
            end
            else if (state_q == IFSI_RDATA && cnt_q >= CNT_FIRST
                && cnt_q <= CNT_LAST)
            begin
                tx_q <= {tx_q[NEXT_POS:0], 1'b0};
                sda_oe_q <= !tx_q[NEXT_POS];
            end
            else
            begin
                // Ack a received byte; released in every other slot
                sda_oe_q <= (state_q != IFSI_RDATA) && (cnt_q == CNT_ACK)
                    && ack_q;
            end
        end
    end

    assign sda_oe = sda_oe_q;
    assign sda_out = sda_out_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_data_done;
        byte_done && state_q == IFSI_WDATA;
    endsequence
    sequence s_ack_fall;
        scl_fall && cnt_q == CNT_ACK && state_q != IFSI_RDATA;
    endsequence
    a_stop_release: assert property (stop_det |=>
        state_q == IFSI_IDLE && !sda_oe_q)
        else $error("stop did not release the bus");
    a_start_ready: assert property (start_det |=>
        state_q == IFSI_DEV && cnt_q == CNT_ZERO && !sda_oe_q)
        else $error("start did not ready the address phase");
    a_read_nack: assert property (state_q == IFSI_RDATA
        && scl_rise && cnt_q == CNT_ACK && sda_s && !start_det
        |=> state_q == IFSI_IDLE ##1 !sda_oe_q)
        else $error("no-ack did not end the read");
    a_wp_blocks: assert property (s_data_done and wp_s |=>
        addr_q == $past(addr_q) && !ack_q)
        else $error("protected write changed the latch");
    a_addr_step: assert property (addr_step |=>
        addr_q == $past(addr_q) + ADDR_ONE)
        else $error("address latch did not step");
    a_write_commit: assert property (mem.we |->
        state_q == IFSI_WDATA && cnt_q == CNT_LAST && scl_rise && !wp_s)
        else $error("write outside the eighth bit");
    a_addr_load: assert property (byte_done
        && state_q == IFSI_ADDR_LO |=> addr_q[DATA_W-1:0] == $past(rx_byte)
        && addr_q[ADDR_W-1:DATA_W] == $past(addr_hi_q))
        else $error("address latch load wrong");
    a_ack_drive: assert property (s_ack_fall and ack_q && !start_det
        && !stop_det |=> sda_oe_q)
        else $error("acknowledge not driven");
    a_dev_miss: assert property (byte_done && state_q == IFSI_DEV
        && !dev_match && !start_det |=> state_q == IFSI_IDLE ##1 !sda_oe_q)
        else $error("unmatched address not ignored");
    a_quiet_rise: assert property (!scl_fall |=>
        sda_oe_q == $past(sda_oe_q) || !sda_oe_q)
        else $error("data driven away from a falling edge");

endmodule : ifsi_slave

// [tb/ifsi_master_model.sv]
// Behavioural two-wire bus master driving the serial clock and data line
`timescale 1ns/1ps
module ifsi_master_model
(
    output logic scl,
    output logic sda_low,
    input wire logic sda_w
);
    localparam realtime Q = 31.25;

    // ----------------------------------------------------------
    // Idle bus
    // ----------------------------------------------------------
    // Clock stands high and data is released between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // ----------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------
    // Start from idle, or a repeated start from a low clock
    task automatic start;
        if (!scl)
        begin
            #Q sda_low = 1'b0;
            #Q scl = 1'b1;
        end
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask : start

    // Stop from a low clock; leaves the bus idle
    task automatic stop;
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop

    // One clock: data set while low, sampled mid-high
    task automatic xfer(input logic b, output logic r);
        #Q sda_low = ~b; // releases the line when b is high
        #Q scl = 1'b1;
        #Q r = sda_w;
        #Q scl = 1'b0;
    endtask : xfer
endmodule : ifsi_master_model

// [tb/i2c_fram_slave_interface_tb_top.sv]
// Self-checking bench for the two-wire memory slave engine
`timescale 1ns/1ps
module i2c_fram_slave_interface_tb_top;
    import ifsi_pkg::*;

    localparam logic [3:0] TB_TYPE = 4'h9; // Arbitrary type code
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic [2:0] cs = 3'h0;
    logic wp = 1'b0;
    wire logic sda_w = ~sda_low & ~(sda_oe & ~sda_out); // Pulled-up wire
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] ref_mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] ref_addr = 13'h0000;

    // ----------------------------------------------------------
    // Clock, design and bus master
    // ----------------------------------------------------------
    always #4 mclk = ~mclk;

    ifsi_slave #(.DEVICE_TYPE(TB_TYPE)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(cs),
        .write_protect(wp));

    ifsi_master_model mst_u (.scl(scl), .sda_low(sda_low), .sda_w(sda_w));

    // ----------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------
    // Byte-level bus tasks
    // ----------------------------------------------------------
    // Send a byte MSB first and check the ack slot
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            mst_u.xfer(b[i], r);
        mst_u.xfer(1'b1, r);
        chk({7'h00, ~r}, {7'h00, exp_ack}, "ack slot");
        chk({7'h00, sda_out}, 8'h00, "drive level");
    endtask : send

    // Receive a byte; how: 0 ack, 1 no-ack, 2 no ack slot
    task automatic recv(input logic [1:0] how, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            mst_u.xfer(1'b1, r);
            d[i] = r;
        end
        if (how != 2'h2)
            mst_u.xfer(how[0], r);
    endtask : recv

    // Device address for a write, then both address bytes
    task automatic hdr(input logic [ADDR_W-1:0] a);
        mst_u.start();
        send({TB_TYPE, cs, 1'b0}, 1'b1);
        send({3'($urandom), a[12:8]}, 1'b1);
        send(a[7:0], 1'b1);
        ref_addr = a;
    endtask : hdr

    // Sequential write of n random bytes
    task automatic wr(input logic [ADDR_W-1:0] a, input int n);
        logic [7:0] d;
        hdr(a);
        repeat (n)
        begin
            d = 8'($urandom);
            send(d, 1'b1);
            ref_mem[ref_addr] = d;
            ref_addr++;
        end
        mst_u.stop();
    endtask : wr

    // Current address read; mode 0 no-ack and stop, 1 stop in the
    // ack slot, 2 no-ack and no stop
    task automatic rd(input int n, input int mode);
        logic [7:0] d;
        mst_u.start();
        send({TB_TYPE, cs, 1'b1}, 1'b1);
        for (int i = 1; i <= n; i++)
        begin
            recv((i < n) ? 2'h0 : ((mode == 1) ? 2'h2 : 2'h1), d);
            chk(d, ref_mem[ref_addr], "read data");
            ref_addr++;
        end
        if (mode != 2)
            mst_u.stop();
    endtask : rd

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        logic [ADDR_W-1:0] a;
        logic r;
        int n;
        void'($urandom(32'h10d9));
        cs = 3'($urandom);
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge mclk);
        // Random writes read back by selective reads
        repeat (4)
        begin
            a = 13'($urandom);
            n = 1 + $urandom_range(3);
            wr(a, n);
            hdr(a);
            rd(n, 0);
        end
        // Sequential access across the top of the array
        wr(13'h1ffe, 4);
        hdr(13'h1ffe);
        rd(2, 2);
        rd(2, 1);
        // Any wrong type or select bit leaves the device silent
        for (int k = 1; k <= 7; k++)
        begin
            mst_u.start();
            send({TB_TYPE, cs, 1'b0} ^ (8'h01 << k), 1'b0);
            send(8'h00, 1'b0);
            mst_u.stop();
        end
        // Protected write: refused, no store, no increment
        @(posedge mclk);
        #1 wp = 1'b1;
        hdr(13'h1fff);
        send(~ref_mem[13'h1fff], 1'b0);
        mst_u.stop();
        @(posedge mclk);
        #1 wp = 1'b0;
        rd(1, 0);
        // Partial byte cut by start or stop writes nothing
        for (int k = 0; k < 2; k++)
        begin
            hdr(13'h1ffe);
            for (int i = 7; i >= 2; i--)
                mst_u.xfer(~ref_mem[13'h1ffe][i], r);
            if (k == 0)
            begin
                mst_u.start();
                send({TB_TYPE, cs, 1'b0}, 1'b1);
            end
            mst_u.stop();
            rd(1, 0);
        end
        report_and_stop();
    end

    // Cuts a hung run short
    initial
    begin
        repeat (50000) @(posedge mclk);
        fail_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        report_and_stop();
    end
endmodule : i2c_fram_slave_interface_tb_top
